// ===== design/sfl_params.svh
// Constants for the settings, fault log and statistics block
`ifndef SFL_PARAMS_SVH
`define SFL_PARAMS_SVH

// ----------------------------------------
// Ranges
// ----------------------------------------
`define SFL_PW_MAX 10'h3E7
`define SFL_CLR_MAX 2'h2
`define SFL_CLR_THERMAL 2'h1
`define SFL_CLR_FACTORY 2'h2
`define SFL_YEAR_BASE 12'h7D0
`define SFL_YEAR_MAX 6'h2F
`define SFL_FAULT_MAX 5'h1B
`define SFL_LOW_MAX 14'h270F
`define SFL_TENTHS_MAX 14'h270F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SFL_RST_YEAR 6'h00
`define SFL_RST_MONTH 4'h1
`define SFL_RST_DAY 5'h01

// ----------------------------------------
// Timing
// ----------------------------------------
`define SFL_CLK_HZ 200000000
`define SFL_SEC_NS 1000000000
`define SFL_CLK_NS 5
`define SFL_SEC_CYCLES (`SFL_SEC_NS / `SFL_CLK_NS)
`define SFL_TENTH_SECONDS 360

`endif

// ===== design/sfl_pkg.sv
// Types for the settings, fault log and statistics block
package sfl_pkg;
  typedef struct packed {
    logic [4:0] code;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [3:0] month;
    logic [4:0] day;
  } sfl_entry_t;
endpackage

// ===== design/sfl_settings.sv
// Settings, calendar clock, fault log and run statistics
`timescale 1ns/10ps
`include "sfl_params.svh"

module sfl_settings
  import sfl_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `SFL_SEC_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Parameter write port
  input wire logic password_write,
  input wire logic [9:0] password_data,
  input wire logic password_ok,
  input wire logic clear_write,
  input wire logic [1:0] clear_data,
  input wire logic clock_write,
  input wire logic [5:0] clock_year_data,
  input wire logic [3:0] clock_month_data,
  input wire logic [4:0] clock_day_data,
  input wire logic [4:0] clock_hour_data,
  input wire logic [5:0] clock_minute_data,
  input wire logic [5:0] clock_second_data,
  // Factory values
  input wire logic [15:0] frame_rating_in,
  input wire logic [15:0] current_transformer_in,
  // Starter status
  input wire logic motor_active,
  input wire logic at_speed,
  input wire logic fault_valid,
  input wire logic [4:0] fault_code,
  // Settings outputs
  output logic [9:0] password_lock_value,
  output logic [1:0] emergency_clear_selector,
  output logic program_unlocked,
  output logic thermal_lockout_clear,
  output logic factory_restore,
  output logic [15:0] frame_rating_readout,
  output logic [15:0] current_transformer_ratio,
  // Calendar outputs
  output logic [11:0] clock_year,
  output logic [3:0] clock_month,
  output logic [4:0] clock_day,
  output logic [4:0] clock_hour,
  output logic [5:0] clock_minute,
  output logic [5:0] clock_second,
  // Fault log outputs
  output sfl_entry_t fault_latest,
  output sfl_entry_t fault_previous,
  output sfl_entry_t fault_oldest,
  // Statistics outputs
  output logic [13:0] run_hours_low,
  output logic [13:0] run_hours_thousands,
  output logic [13:0] run_count_low,
  output logic [13:0] run_count_ten_thousands
);

  // ----------------------------------------
  // Settings
  // ----------------------------------------
  logic [9:0] pw_reg;
  logic [1:0] clr_reg;
  logic [31:0] sec_cnt_reg;
  logic sec_tick;
  logic [8:0] tenth_cnt_reg;
  logic [5:0] year_reg;
  logic [3:0] month_reg;
  logic [4:0] day_reg;
  logic [4:0] hour_reg;
  logic [5:0] minute_reg;
  logic [5:0] second_reg;
  logic [4:0] days_in_month;
  logic leap_year;
  sfl_entry_t log_reg [3];
  logic at_speed_prev_reg;
  logic [13:0] hrs_low_reg, hrs_k_reg, cnt_low_reg, cnt_k_reg;
  logic write_allowed;
  logic [15:0] frame_reg;
  logic [15:0] ct_reg;

  assign write_allowed = (pw_reg == 10'h000) || password_ok;
  assign program_unlocked = write_allowed;

  // Password store, untouched by factory restore
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pw_reg <= 10'h000;
    end else if (password_write && write_allowed && password_data <= `SFL_PW_MAX) begin
      pw_reg <= password_data;
    end
  end

  // One-shot clear selector
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clr_reg <= 2'h0;
    end else if (clr_reg != 2'h0) begin
      clr_reg <= 2'h0;
    end else if (clear_write && write_allowed && clear_data <= `SFL_CLR_MAX) begin
      clr_reg <= clear_data;
    end
  end

  assign thermal_lockout_clear = (clr_reg == `SFL_CLR_THERMAL);
  assign factory_restore = (clr_reg == `SFL_CLR_FACTORY);
  assign password_lock_value = pw_reg;
  assign emergency_clear_selector = clr_reg;
  // Factory values sampled every cycle; no user write path reaches them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_reg <= 16'h0000;
      ct_reg <= 16'h0000;
    end else begin
      frame_reg <= frame_rating_in;
      ct_reg <= current_transformer_in;
    end
  end
  assign frame_rating_readout = frame_reg;
  assign current_transformer_ratio = ct_reg;

  // ----------------------------------------
  // Calendar clock
  // ----------------------------------------
  // One-second enable pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_cnt_reg <= 32'h0000_0000;
    end else if (sec_tick) begin
      sec_cnt_reg <= 32'h0000_0000;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
    end
  end
  assign sec_tick = (sec_cnt_reg == 32'(SEC_CYCLES - 1));

  // Month length with leap years; 2000 base so year mod 4 suffices
  assign leap_year = (year_reg[1:0] == 2'b00);
  always_comb begin
    case (month_reg)
      4'h2: days_in_month = leap_year ? 5'd29 : 5'd28;
      4'h4, 4'h6, 4'h9, 4'hB: days_in_month = 5'd30;
      default: days_in_month = 5'd31;
    endcase
  end

  // Time and date advance, or load from operator
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      year_reg <= `SFL_RST_YEAR;
      month_reg <= `SFL_RST_MONTH;
      day_reg <= `SFL_RST_DAY;
      hour_reg <= 5'h00;
      minute_reg <= 6'h00;
      second_reg <= 6'h00;
    end else if (clock_write && write_allowed) begin
      if (clock_year_data <= `SFL_YEAR_MAX) year_reg <= clock_year_data;
      if (clock_month_data >= 4'h1 && clock_month_data <= 4'hC) month_reg <= clock_month_data;
      if (clock_day_data >= 5'h01) day_reg <= clock_day_data;
      if (clock_hour_data <= 5'd23) hour_reg <= clock_hour_data;
      if (clock_minute_data <= 6'd59) minute_reg <= clock_minute_data;
      if (clock_second_data <= 6'd59) second_reg <= clock_second_data;
    end else if (sec_tick) begin
      if (second_reg != 6'd59) begin
        second_reg <= second_reg + 6'd1;
      end else begin
        second_reg <= 6'd0;
        if (minute_reg != 6'd59) begin
          minute_reg <= minute_reg + 6'd1;
        end else begin
          minute_reg <= 6'd0;
          if (hour_reg != 5'd23) begin
            hour_reg <= hour_reg + 5'd1;
          end else begin
            hour_reg <= 5'd0;
            if (day_reg < days_in_month) begin
              day_reg <= day_reg + 5'd1;
            end else begin
              day_reg <= 5'd1;
              if (month_reg != 4'hC) begin
                month_reg <= month_reg + 4'h1;
              end else begin
                month_reg <= 4'h1;
                year_reg <= (year_reg == `SFL_YEAR_MAX) ? 6'd0 : year_reg + 6'd1;
              end
            end
          end
        end
      end
    end
  end

  assign clock_year = `SFL_YEAR_BASE + {6'h00, year_reg};
  assign clock_month = month_reg;
  assign clock_day = day_reg;
  assign clock_hour = hour_reg;
  assign clock_minute = minute_reg;
  assign clock_second = second_reg;

  // ----------------------------------------
  // Fault log
  // ----------------------------------------
  // Shift on new fault, clear on factory restore; a fault in the restore cycle shifts in and the clear is skipped
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 3; i++) log_reg[i] <= '0;
    end else if (fault_valid && fault_code != 5'h00 && fault_code <= `SFL_FAULT_MAX) begin
      log_reg[2] <= log_reg[1];
      log_reg[1] <= log_reg[0];
      log_reg[0] <= '{code: fault_code, hour: hour_reg, minute: minute_reg,
                      month: month_reg, day: day_reg};
    end else if (factory_restore) begin
      for (int i = 0; i < 3; i++) log_reg[i] <= '0;
    end
  end

  assign fault_latest = log_reg[0];
  assign fault_previous = log_reg[1];
  assign fault_oldest = log_reg[2];

  // ----------------------------------------
  // Run statistics
  // ----------------------------------------
  // Run hour tenths: 360 active seconds per tenth
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tenth_cnt_reg <= 9'h000;
      hrs_low_reg <= 14'h0000;
      hrs_k_reg <= 14'h0000;
    end else if (sec_tick && motor_active) begin
      if (tenth_cnt_reg != 9'(`SFL_TENTH_SECONDS - 1)) begin
        tenth_cnt_reg <= tenth_cnt_reg + 9'h001;
      end else begin
        tenth_cnt_reg <= 9'h000;
        if (hrs_low_reg != `SFL_TENTHS_MAX) begin
          hrs_low_reg <= hrs_low_reg + 14'h0001;
        end else begin
          hrs_low_reg <= 14'h0000;
          if (hrs_k_reg != `SFL_LOW_MAX) hrs_k_reg <= hrs_k_reg + 14'h0001;
        end
      end
    end
  end

  // Run cycles counted on rising at-speed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      at_speed_prev_reg <= 1'b0;
      cnt_low_reg <= 14'h0000;
      cnt_k_reg <= 14'h0000;
    end else begin
      at_speed_prev_reg <= at_speed;
      if (at_speed && !at_speed_prev_reg) begin
        if (cnt_low_reg != `SFL_LOW_MAX) begin
          cnt_low_reg <= cnt_low_reg + 14'h0001;
        end else begin
          cnt_low_reg <= 14'h0000;
          if (cnt_k_reg != `SFL_LOW_MAX) cnt_k_reg <= cnt_k_reg + 14'h0001;
        end
      end
    end
  end

  assign run_hours_low = hrs_low_reg;
  assign run_hours_thousands = hrs_k_reg;
  assign run_count_low = cnt_low_reg;
  assign run_count_ten_thousands = cnt_k_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_clear_one_shot: assert property (@(posedge clk) disable iff (sys_rst)
    (clr_reg != 2'h0) |=> (clr_reg == 2'h0)) else $error("clear selector not one-shot");
  a_lock_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (pw_reg == 10'h000) |-> program_unlocked) else $error("zero password still locks");
  a_pw_kept: assert property (@(posedge clk) disable iff (sys_rst)
    (factory_restore && !password_write) |=> $stable(pw_reg)) else $error("password changed");
  a_hour_range: assert property (@(posedge clk) disable iff (sys_rst)
    (hour_reg <= 5'd23) && (minute_reg <= 6'd59)) else $error("time out of range");
  a_month_range: assert property (@(posedge clk) disable iff (sys_rst)
    (month_reg >= 4'h1) && (month_reg <= 4'hC)) else $error("month out of range");
  a_log_shift: assert property (@(posedge clk) disable iff (sys_rst)
    (fault_valid && fault_code != 5'h00 && fault_code <= 5'd27) |=>
    (log_reg[1] == $past(log_reg[0])) && (log_reg[0].code == $past(fault_code)))
    else $error("fault log did not shift");
  a_log_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (factory_restore && !fault_valid) |=> (log_reg[0] == '0) && (log_reg[2] == '0))
    else $error("fault log not cleared");
  a_count_start: assert property (@(posedge clk) disable iff (sys_rst)
    (!at_speed_prev_reg && !at_speed) |=> $stable(cnt_low_reg)) else $error("run count moved");
  a_idle_hours: assert property (@(posedge clk) disable iff (sys_rst)
    !motor_active |=> $stable(hrs_low_reg)) else $error("hours grew while idle");
  a_locked_write: assert property (@(posedge clk) disable iff (sys_rst)
    (pw_reg != 10'h000 && !password_ok) |=> $stable(pw_reg))
    else $error("locked password changed");
  a_pw_range: assert property (@(posedge clk) disable iff (sys_rst)
    pw_reg <= `SFL_PW_MAX) else $error("password out of range");
  a_clear_range: assert property (@(posedge clk) disable iff (sys_rst)
    clr_reg <= `SFL_CLR_MAX) else $error("clear selector out of range");
  a_thermal_set: assert property (@(posedge clk) disable iff (sys_rst)
    (clear_write && write_allowed && clr_reg == 2'h0 && clear_data == `SFL_CLR_THERMAL) |=>
    thermal_lockout_clear) else $error("thermal clear pulse missing");
  a_factory_set: assert property (@(posedge clk) disable iff (sys_rst)
    (clear_write && write_allowed && clr_reg == 2'h0 && clear_data == `SFL_CLR_FACTORY) |=>
    factory_restore) else $error("factory restore pulse missing");
  a_date_range: assert property (@(posedge clk) disable iff (sys_rst)
    (day_reg >= 5'h01) && (year_reg <= `SFL_YEAR_MAX)) else $error("date out of range");
  a_second_range: assert property (@(posedge clk) disable iff (sys_rst)
    second_reg <= 6'd59) else $error("second out of range");
  a_leap_day: assert property (@(posedge clk) disable iff (sys_rst)
    (sec_tick && !clock_write && month_reg == 4'h2 && day_reg == 5'd28 && hour_reg == 5'd23 &&
    minute_reg == 6'd59 && second_reg == 6'd59) |=>
    (($past(year_reg[1:0]) == 2'b00) == (day_reg == 5'd29))) else $error("leap day wrong");
  a_stamp_range: assert property (@(posedge clk) disable iff (sys_rst)
    (log_reg[0].hour <= 5'd23) && (log_reg[0].minute <= 6'd59) && (log_reg[0].month <= 4'hC))
    else $error("fault stamp out of range");
  a_code_range: assert property (@(posedge clk) disable iff (sys_rst)
    (log_reg[0].code <= `SFL_FAULT_MAX) && (log_reg[2].code <= `SFL_FAULT_MAX))
    else $error("fault code out of range");
  a_log_stamp: assert property (@(posedge clk) disable iff (sys_rst)
    (fault_valid && fault_code != 5'h00 && fault_code <= `SFL_FAULT_MAX) |=>
    (log_reg[0].hour == $past(hour_reg)) && (log_reg[0].minute == $past(minute_reg)) &&
    (log_reg[0].month == $past(month_reg)) && (log_reg[0].day == $past(day_reg)))
    else $error("fault stamp wrong");
  a_hours_carry: assert property (@(posedge clk) disable iff (sys_rst)
    (sec_tick && motor_active && tenth_cnt_reg == 9'(`SFL_TENTH_SECONDS - 1) &&
    hrs_low_reg == `SFL_TENTHS_MAX) |=> (hrs_low_reg == 14'h0000))
    else $error("run hours did not carry");
  a_count_carry: assert property (@(posedge clk) disable iff (sys_rst)
    (at_speed && !at_speed_prev_reg && cnt_low_reg == `SFL_LOW_MAX && cnt_k_reg != `SFL_LOW_MAX)
    |=> (cnt_low_reg == 14'h0000) && (cnt_k_reg == $past(cnt_k_reg) + 14'h0001))
    else $error("run count did not carry");

endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the settings, fault log and statistics block
`timescale 1ns/10ps

module tb_top;
  import sfl_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int SC = 4;
  logic clk, sys_rst, password_write, password_ok, clear_write, clock_write;
  logic motor_active, at_speed, fault_valid;
  logic [9:0] password_data, password_lock_value;
  logic [1:0] clear_data, emergency_clear_selector;
  logic [5:0] y_d, mi_d, s_d, clock_minute, clock_second;
  logic [3:0] mo_d, clock_month;
  logic [4:0] d_d, h_d, fault_code, clock_day, clock_hour;
  logic [15:0] frame_in, ct_in, frame_out, ct_out;
  logic program_unlocked, thermal_lockout_clear, factory_restore;
  logic [11:0] clock_year;
  sfl_entry_t f1, f2, f3, e;
  logic [13:0] hl, hk, cl, ck;
  int errors, comparisons;
  logic [5:0] cy [3] = '{6'h2F, 6'h04, 6'h01};
  logic [3:0] cm [3] = '{4'hC, 4'h2, 4'h2};
  logic [4:0] cd [3] = '{5'h1F, 5'h1C, 5'h1C};
  logic [3:0] nm [3] = '{4'h1, 4'h2, 4'h3};
  logic [4:0] nd [3] = '{5'h01, 5'h1D, 5'h01};
  logic [5:0] ny [3] = '{6'h00, 6'h04, 6'h01};

  sfl_settings #(.SEC_CYCLES(SC)) uut (.clk(clk), .sys_rst(sys_rst),
    .password_write(password_write), .password_data(password_data),
    .password_ok(password_ok), .clear_write(clear_write), .clear_data(clear_data),
    .clock_write(clock_write), .clock_year_data(y_d), .clock_month_data(mo_d),
    .clock_day_data(d_d), .clock_hour_data(h_d), .clock_minute_data(mi_d),
    .clock_second_data(s_d), .frame_rating_in(frame_in), .current_transformer_in(ct_in),
    .motor_active(motor_active), .at_speed(at_speed), .fault_valid(fault_valid),
    .fault_code(fault_code), .password_lock_value(password_lock_value),
    .emergency_clear_selector(emergency_clear_selector),
    .program_unlocked(program_unlocked), .thermal_lockout_clear(thermal_lockout_clear),
    .factory_restore(factory_restore), .frame_rating_readout(frame_out),
    .current_transformer_ratio(ct_out), .clock_year(clock_year),
    .clock_month(clock_month), .clock_day(clock_day), .clock_hour(clock_hour),
    .clock_minute(clock_minute), .clock_second(clock_second), .fault_latest(f1),
    .fault_previous(f2), .fault_oldest(f3), .run_hours_low(hl),
    .run_hours_thousands(hk), .run_count_low(cl), .run_count_ten_thousands(ck));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_pw(input logic [9:0] v);
    @(negedge clk) begin password_data = v; password_write = 1'b1; end
    @(negedge clk) password_write = 1'b0;
  endtask
  task automatic wr_clr(input logic [1:0] v);
    @(negedge clk) begin clear_data = v; clear_write = 1'b1; end
    @(negedge clk) clear_write = 1'b0;
  endtask
  task automatic wr_clk(input logic [5:0] y, input logic [3:0] mo, input logic [4:0] d,
                        input logic [4:0] h, input logic [5:0] mi, input logic [5:0] s);
    @(negedge clk) begin y_d = y; mo_d = mo; d_d = d; h_d = h; mi_d = mi; s_d = s; end
    clock_write = 1'b1;
    @(negedge clk) clock_write = 1'b0;
  endtask
  task automatic fault(input logic [4:0] c);
    @(negedge clk) begin fault_code = c; fault_valid = 1'b1; end
    @(negedge clk) fault_valid = 1'b0;
  endtask
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    conclude();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    {password_write, clear_write, clock_write, motor_active, at_speed, fault_valid} = 6'h00;
    {password_data, clear_data, y_d, mo_d, d_d, h_d, mi_d, s_d, fault_code} = '0;
    password_ok = 1'b0;
    frame_in = 16'hA5C3;
    ct_in = 16'h0320;
    errors = 0;
    comparisons = 0;
    cyc(3);
    sys_rst = 1'b0;
    // Reset values and read-only readouts
    check(clock_year, 12'h7D0);
    check({clock_month, clock_day}, {4'h1, 5'h01});
    check({password_lock_value, emergency_clear_selector}, 12'h000);
    check({f1, f2, f3}, 75'h0);
    check({frame_out, ct_out}, 32'h0000_0000);
    $display("test reset done");
    // Password lock
    check(program_unlocked, 1'b1);
    wr_pw(10'h1F4);
    check(password_lock_value, 10'h1F4);
    check(program_unlocked, 1'b0);
    check({frame_out, ct_out}, {16'hA5C3, 16'h0320});
    wr_pw(10'h007);
    wr_clr(2'h1);
    check({password_lock_value, emergency_clear_selector}, {10'h1F4, 2'h0});
    password_ok = 1'b1;
    wr_pw(10'h3E8);
    check(password_lock_value, 10'h1F4);
    wr_pw(10'h3E7);
    check(password_lock_value, 10'h3E7);
    $display("test password done");
    // Emergency clear one-shot
    wr_clr(2'h1);
    check({emergency_clear_selector, thermal_lockout_clear, factory_restore}, 4'h6);
    cyc(1);
    check({emergency_clear_selector, thermal_lockout_clear}, 3'h0);
    wr_clr(2'h3);
    check({emergency_clear_selector, thermal_lockout_clear, factory_restore}, 4'h0);
    $display("test clear done");
    // Fault history shift and stamps
    wr_clk(6'h05, 4'h9, 5'h03, 5'h0F, 6'h13, 6'h00);
    check({clock_year, clock_hour, clock_minute}, {12'h7D5, 5'h0F, 6'h13});
    fault(5'h05);
    fault(5'h07);
    fault(5'h09);
    fault(5'h00);
    fault(5'h1C);
    fault(5'h1B);
    e = {5'h1B, 5'h0F, 6'h13, 4'h9, 5'h03};
    check(f1, e);
    e.code = 5'h09;
    check(f2, e);
    e.code = 5'h07;
    check(f3, e);
    $display("test fault log done");
    // Factory restore
    wr_clr(2'h2);
    check({emergency_clear_selector, factory_restore}, 3'h5);
    cyc(1);
    check({f1, f2, f3}, 75'h0);
    check(password_lock_value, 10'h3E7);
    $display("test factory done");
    // Calendar rollover, leap years and field refusal
    for (int i = 0; i < 3; i++) begin
      wr_clk(cy[i], cm[i], cd[i], 5'h17, 6'h3B, 6'h3B);
      cyc(2 * SC + 2);
      check({clock_year, clock_month, clock_day}, {12'h7D0 + ny[i], nm[i], nd[i]});
      check({clock_hour, clock_minute}, 11'h000);
    end
    wr_clk(6'h01, 4'hD, 5'h05, 5'h18, 6'h0A, 6'h0A);
    check({clock_month, clock_day, clock_hour, clock_minute, clock_second},
          {4'h3, 5'h05, 5'h00, 6'h0A, 6'h0A});
    $display("test calendar done");
    // Run time and run cycle counters
    motor_active = 1'b1;
    cyc(360 * SC + 8);
    motor_active = 1'b0;
    check({hl, cl}, {14'h0001, 14'h0000});
    cyc(360 * SC + 60);
    check(hl, 14'h0001);
    for (int i = 0; i < 3; i++) begin
      @(negedge clk) at_speed = 1'b1;
      cyc(2);
      at_speed = 1'b0;
      cyc(1);
    end
    check({cl, ck, hk}, {14'h0003, 14'h0000, 14'h0000});
    // Push the low run count through its wrap into the high counter
    repeat (9997) begin
      @(negedge clk) at_speed = 1'b1;
      @(negedge clk) at_speed = 1'b0;
    end
    check({cl, ck}, {14'h0000, 14'h0001});
    $display("test statistics done");
    conclude();
  end
endmodule
